// ### dv/sent_frame_pulse_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sent_frame_pulse_timing_tb;
  // tick 20 percent short of 3 us: receiver must rescale
  localparam int unsigned TC = 601;

  logic        ref_clk;
  logic        rst_n;
  logic [27:0] in_data;
  logic        in_valid;
  logic        in_ready;
  logic [2:0]  tx_nibs;
  logic        pause_en;
  logic [3:0]  rx_nibs;
  logic        rx_valid;
  logic [3:0]  rx_status;
  logic [31:0] rx_data;
  logic        rx_crc_ok;
  logic        rx_err;
  logic [23:0] rx_cal;
  logic        bad_err;
  logic        tx_start;
  int          start_cnt = 0;
  logic        line_d = 1'b1;
  int          per_cnt = 0;
  int          low_cnt = 0;
  int          per_q[$];
  int          low_q[$];
  int          err_count = 0;
  int          check_count = 0;

  snt_link_if link_if ();
  snt_link_if bad_if ();

  snt_tx #(.TICK_CYC(TC)) snt_tx_inst (
    .link(link_if), .ref_clk(ref_clk), .rst_n(rst_n),
    .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
    .nib_cnt(tx_nibs), .pause_en(pause_en), .frame_start(tx_start));
  snt_rx snt_rx_inst (
    .link(link_if), .ref_clk(ref_clk), .rst_n(rst_n), .nib_cnt(rx_nibs),
    .frame_valid(rx_valid), .frame_status(rx_status), .frame_data(rx_data),
    .frame_crc_ok(rx_crc_ok), .frame_err(rx_err), .cal_cycles(rx_cal));
  snt_rx snt_rx_err_inst (
    .link(bad_if), .ref_clk(ref_clk), .rst_n(rst_n), .nib_cnt(4'h1),
    .frame_valid(), .frame_status(), .frame_data(), .frame_crc_ok(),
    .frame_err(bad_err), .cal_cycles());
  snt_link_chk #(.TICK_CYC(TC)) snt_link_chk_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .tx_out(link_if.tx_out),
    .tx_oe(link_if.tx_oe), .line(link_if.line));

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // falls and low phases seen on the joined wire
  always @(posedge ref_clk)
  begin
    line_d <= link_if.line;
    // frame start must coincide with a calibration fall
    if (tx_start && line_d && !link_if.line)
      start_cnt <= start_cnt + 1;
    if (line_d && !link_if.line)
    begin
      if (per_cnt > 0)
        per_q.push_back(per_cnt);
      per_cnt <= 1;
    end
    else if (per_cnt > 0)
      per_cnt <= per_cnt + 1;
    if (!link_if.line)
      low_cnt <= low_cnt + 1;
    else if (!line_d)
    begin
      low_q.push_back(low_cnt);
      low_cnt <= 0;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic [3:0] crc_of(logic [31:0] d, int n);
    logic [3:0] c;
    c = 4'h3;
    for (int i = 0; i < n; i++)
      c = ({c[2:0], 1'b0} ^ (c[3] ? 4'h9 : 4'h0)) ^ d[4*i +: 4];
    return c;
  endfunction

  task automatic t_reset();
    repeat (10) @(negedge ref_clk);
    check(32'(link_if.line), 32'h1);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check(32'(link_if.line), 32'h0);
    $display("test reset done");
  endtask

  // fill the word buffer until it refuses
  task automatic t_fill();
    int n;
    n = 0;
    for (int i = 0; i < 12; i++)
    begin
      if (in_ready !== 1'b1)
        break;
      in_data  = {4'(n), 20'h0, 4'(15 - n)};
      in_valid = 1'b1;
      n++;
      @(negedge ref_clk);
    end
    in_valid = 1'b0;
    check(32'(n), 32'h8);
    $display("test fill done");
  endtask

  task automatic t_wire();
    int e[$];
    int i;
    e = {56, 12, 12, 12, 12, 12, 12, 12, 12 + int'(crc_of(32'h0, 6)),
         56, 12, 27, 12 + int'(crc_of(32'hF, 1)), 12};
    for (i = 0; i < 300000 && per_q.size() < 14; i++)
      @(negedge ref_clk);
    for (i = 0; i < 14; i++)
    begin
      check(32'(per_q[i]), 32'(e[i] * TC));
      check(32'(low_q[i]), 32'(5 * TC));
    end
    check(32'(start_cnt), 32'h2);
    $display("test wire timing done");
  endtask

  task automatic t_rx(input logic [3:0] st, input logic [31:0] d);
    for (int i = 0; i < 300000 && rx_valid !== 1'b1; i++)
      @(negedge ref_clk);
    check(32'(rx_status), 32'(st));
    check(rx_data, d);
    check(32'(rx_crc_ok), 32'h1);
    check(32'(rx_cal), 32'(56 * TC));
    check(32'(rx_err), 32'h0);
    @(negedge ref_clk);
    $display("test frame done");
  endtask

  task automatic bad_pulse(input int ticks);
    bad_if.tx_oe = 1'b1;
    repeat (5 * TC) @(negedge ref_clk);
    bad_if.tx_oe = 1'b0;
    repeat ((ticks - 5) * TC) @(negedge ref_clk);
  endtask

  // a 30-tick nibble after a good calibration
  task automatic t_bad();
    bad_pulse(56);
    bad_pulse(30);
    bad_if.tx_oe = 1'b1;
    for (int i = 0; i < 8 && bad_err !== 1'b1; i++)
      @(negedge ref_clk);
    check(32'(bad_err), 32'h1);
    bad_if.tx_oe = 1'b0;
    $display("test bad nibble done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    in_data = 28'h0;
    in_valid = 1'b0;
    tx_nibs = 3'h1;
    pause_en = 1'b1;
    rx_nibs = 4'h6;
    bad_if.tx_out = 1'b0;
    bad_if.tx_oe = 1'b0;
    t_reset();
    fork
      t_fill();
      t_wire();
      t_bad();
      begin
        // first frame after reset carries six zero nibbles
        t_rx(4'h0, 32'h0);
        rx_nibs = 4'h1;
        t_rx(4'h0, 32'hF);
        t_rx(4'h1, 32'hE);
      end
    join
    give_verdict();
  end

  initial
  begin
    repeat (400000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end
endmodule

`default_nettype wire

// ### dv/snt_link_chk.sv
`timescale 1ns/1ps
`default_nettype none

module snt_link_chk #(
  parameter int unsigned TICK_CYC = 750
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // wire
  input  wire logic tx_out,
  input  wire logic tx_oe,
  input  wire logic line
);
  localparam int unsigned CAL = 56 * TICK_CYC;
  localparam int unsigned T = TICK_CYC;

  logic        line_d_r;
  logic        armed_r;
  logic        cal_r;
  logic [31:0] per_r;
  logic [31:0] low_r;
  logic [31:0] hi_r;
  logic [3:0]  pos_r;
  logic        fall;
  logic        is_cal;

  assign fall   = line_d_r && !line;
  assign is_cal = per_r == CAL;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      line_d_r <= 1'b1;
      armed_r  <= 1'b0;
      per_r    <= 32'h0;
    end
    else
    begin
      line_d_r <= line;
      armed_r  <= armed_r || fall;
      per_r    <= fall ? 32'h1 : per_r + 32'h1;
    end
  end

  // low and high phase lengths
  always_ff @(posedge ref_clk)
  begin
    low_r <= (rst_n && tx_oe) ? low_r + 32'h1 : 32'h0;
    hi_r  <= (rst_n && !tx_oe) ? hi_r + 32'h1 : 32'h0;
  end

  // pulses counted since the last calibration period
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cal_r <= 1'b0;
      pos_r <= 4'h0;
    end
    else if (fall && armed_r)
    begin
      cal_r <= cal_r || is_cal;
      pos_r <= is_cal ? 4'h0 : pos_r + 4'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  start_on_release_a: assert property ($rose(rst_n) |=> tx_oe)
    else $error("no pulse after reset");
  drive_low_a: assert property (tx_oe |-> !tx_out)
    else $error("enabled driver not low");
  low_time_a: assert property ($fell(tx_oe) |-> low_r == 5 * T)
    else $error("low phase length wrong");
  period_a: assert property (fall && armed_r |-> is_cal ||
    (per_r >= 12 * T && per_r <= 27 * T && per_r % T == 0))
    else $error("pulse period off grid");
  first_cal_a: assert property (fall && armed_r && !cal_r &&
    pos_r == 4'h0 |-> is_cal)
    else $error("frame does not open with calibration");
  pulse_count_a: assert property (fall && armed_r && is_cal &&
    cal_r |-> pos_r >= 4'h3 && pos_r <= 4'h9)
    else $error("pulse count per frame wrong");
  high_rest_a: assert property ($rose(tx_oe) && armed_r |->
    hi_r >= 7 * T)
    else $error("high phase too short");
  no_gap_a: assert property (armed_r |-> per_r <= CAL)
    else $error("gap between pulses");

  cover property (fall && armed_r && is_cal);
  cover property (fall && armed_r && is_cal && cal_r && pos_r == 4'h4);
  cover property ($rose(rst_n));
endmodule

`default_nettype wire

// ### hdl/snt_link_if.sv
`timescale 1ns/1ps
`default_nettype none

// single open-drain wire with pull-up; only the transmitter pulls it low
interface snt_link_if;
  logic tx_out;
  logic tx_oe;
  logic line;

  assign line = tx_oe ? tx_out : 1'b1;

  modport tx (output tx_out, output tx_oe, input line);
  modport rx (input line);
endinterface

`default_nettype wire

// ### hdl/snt_map.svh
`ifndef SNT_MAP_SVH
`define SNT_MAP_SVH

// clock and tick timing
`define SNT_CLK_NS        4
`define SNT_TICK_NS       3000
`define SNT_TICK_MIN_NS   3000
`define SNT_TICK_MAX_NS   90000
`define SNT_TOL_PCT       20
`define SNT_TICK_CYC      ((`SNT_TICK_NS + `SNT_CLK_NS - 1) / `SNT_CLK_NS)
`define SNT_FRAME_MAX_NS  1000000

// pulse lengths in ticks
`define SNT_CAL_TICKS     56
`define SNT_NIB_TICKS     12
`define SNT_NIB_MAX_TICKS 27
`define SNT_LOW_TICKS     5
`define SNT_PAUSE_TICKS   12

// nibble counts and field layout of a transmit word
`define SNT_TX_NIBS       6
`define SNT_RX_NIBS       8
`define SNT_TX_W          28
`define SNT_STAT_LSB      24
`define SNT_FIFO_DEPTH    8

// checksum seed and feedback taps
`define SNT_CRC_SEED      4'h3
`define SNT_CRC_POLY      4'h9

// calibration windows: absolute in cycles, relative in scaled ticks
`define SNT_CAL_MIN_CYC   (`SNT_CAL_TICKS * `SNT_TICK_MIN_NS * \
                           (100 - `SNT_TOL_PCT) / 100 / `SNT_CLK_NS)
`define SNT_CAL_MAX_CYC   (`SNT_CAL_TICKS * `SNT_TICK_MAX_NS * \
                           (100 + `SNT_TOL_PCT) / 100 / `SNT_CLK_NS)
`define SNT_CAL_T_LO      50
`define SNT_CAL_T_HI      62

`endif

// ### hdl/snt_pkg.sv
`include "snt_map.svh"

package snt_pkg;

  typedef enum logic [2:0]
  {
    SNT_TX_CAL   = 3'h0,
    SNT_TX_STAT  = 3'h1,
    SNT_TX_DATA  = 3'h2,
    SNT_TX_CRC   = 3'h3,
    SNT_TX_PAUSE = 3'h4
  } snt_tx_state_e;

  typedef enum logic [2:0]
  {
    SNT_RX_HUNT  = 3'h0,
    SNT_RX_STAT  = 3'h1,
    SNT_RX_DATA  = 3'h2,
    SNT_RX_CRC   = 3'h3,
    SNT_RX_TAIL  = 3'h4,
    SNT_RX_PAUSE = 3'h5
  } snt_rx_state_e;

  typedef logic [31:0] snt_nibs_t;

  // nibble 0 sits in bits 3:0 and goes out first
  function automatic logic [3:0] snt_nib(snt_nibs_t d, logic [2:0] i);
    snt_nib = d[{i, 2'b00} +: 4];
  endfunction

  // status nibble stays outside the checksum
  function automatic logic [3:0] snt_crc(snt_nibs_t d, logic [3:0] n);
    logic [3:0] c;
    c = `SNT_CRC_SEED;
    for (int i = 0; i < 8; i++)
    begin
      if (4'(i) < n)
        c = ({c[2:0], 1'b0} ^ (c[3] ? `SNT_CRC_POLY : 4'h0))
            ^ snt_nib(d, 3'(i));
    end
    snt_crc = c;
  endfunction

endpackage

// ### hdl/snt_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "snt_map.svh"

module snt_rx
  import snt_pkg::*;
(
  // link
  snt_link_if.rx               link,
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  // data nibbles per frame, 1 to 8
  input  wire logic [3:0]      nib_cnt,
  // decoded frame
  output logic                 frame_valid,
  output logic [3:0]           frame_status,
  output logic [31:0]          frame_data,
  output logic                 frame_crc_ok,
  output logic                 frame_err,
  output logic [23:0]          cal_cycles
);
  // scaled ticks = round(period * 56 / cal), without a divider
  function automatic logic [6:0] ticks_of(logic [23:0] p, logic [23:0] c);
    logic [31:0] pp;
    pp       = {8'h00, p} * 32'd112;
    ticks_of = 7'h00;
    for (int k = 1; k < 64; k++)
    begin
      if (pp >= {8'h00, c} * 32'(2 * k - 1))
        ticks_of = 7'(k);
    end
  endfunction

  logic          line_d_r;
  logic          fall;
  logic          seen_r;
  logic [23:0]   per_r;
  logic [23:0]   cal_r;
  logic [6:0]    t;
  logic [3:0]    val;
  logic          nib_ok;
  logic          cal_abs;
  logic          cal_like;
  logic [3:0]    n;
  snt_rx_state_e st_r;
  logic [2:0]    idx_r;
  logic [31:0]   work_r;
  logic [3:0]    stat_r;

  assign fall     = line_d_r && !link.line; // RULE_18
  assign t        = ticks_of(per_r, cal_r); // RULE_14
  assign val      = 4'(t - 7'(`SNT_NIB_TICKS)); // RULE_12
  assign nib_ok   = (t >= 7'(`SNT_NIB_TICKS)) &&
                    (t <= 7'(`SNT_NIB_MAX_TICKS)); // RULE_20
  assign cal_abs  = (per_r >= 24'(`SNT_CAL_MIN_CYC)) &&
                    (per_r <= 24'(`SNT_CAL_MAX_CYC)); // RULE_03 RULE_04
  assign cal_like = cal_abs && (t >= 7'(`SNT_CAL_T_LO)) &&
                    (t <= 7'(`SNT_CAL_T_HI));
  assign n        = (nib_cnt == 4'h0 || nib_cnt > 4'(`SNT_RX_NIBS)) ?
                    4'(`SNT_RX_NIBS) : nib_cnt; // RULE_17 RULE_09

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      line_d_r <= 1'b1;
    else
      line_d_r <= link.line;
  end

  // saturating period counter; a stuck line never wraps into a fake pulse
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      per_r <= '0;
    else if (fall)
      per_r <= 24'h000001;
    else if (per_r != 24'hFFFFFF)
      per_r <= per_r + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      seen_r <= 1'b0;
    else if (fall)
      seen_r <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r   <= SNT_RX_HUNT;
      cal_r  <= 24'h000001;
      idx_r  <= 3'h0;
      work_r <= '0;
      stat_r <= 4'h0;
    end
    else if (fall && seen_r)
    begin
      case (st_r)
        SNT_RX_HUNT:
        begin
          if (cal_abs)
          begin
            cal_r <= per_r; // RULE_14
            st_r  <= SNT_RX_STAT;
          end
        end
        SNT_RX_STAT, SNT_RX_DATA, SNT_RX_CRC:
        begin
          if (cal_like)
          begin
            cal_r <= per_r;
            st_r  <= SNT_RX_STAT;
          end
          else if (!nib_ok)
            st_r <= SNT_RX_HUNT; // RULE_20
          else if (st_r == SNT_RX_STAT)
          begin
            stat_r <= val; // RULE_05
            work_r <= '0;
            idx_r  <= 3'h0;
            st_r   <= SNT_RX_DATA;
          end
          else if (st_r == SNT_RX_DATA)
          begin
            work_r[{idx_r, 2'b00} +: 4] <= val;
            idx_r <= idx_r + 1'b1;
            if ({1'b0, idx_r} == n - 1'b1)
              st_r <= SNT_RX_CRC;
          end
          else
            st_r <= SNT_RX_TAIL;
        end
        SNT_RX_TAIL, SNT_RX_PAUSE:
        begin
          if (cal_like)
          begin
            cal_r <= per_r;
            st_r  <= SNT_RX_STAT;
          end
          else if (st_r == SNT_RX_TAIL)
            st_r <= SNT_RX_PAUSE; // RULE_11
          else
            st_r <= SNT_RX_HUNT;
        end
        default:
          st_r <= SNT_RX_HUNT;
      endcase
    end
  end

  // a frame is handed out on its checksum edge, good or bad
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      frame_valid  <= 1'b0;
      frame_status <= 4'h0;
      frame_data   <= '0;
      frame_crc_ok <= 1'b0;
    end
    else
    begin
      frame_valid <= fall && seen_r && (st_r == SNT_RX_CRC) &&
                     nib_ok && !cal_like;
      if (fall && seen_r && (st_r == SNT_RX_CRC) && nib_ok && !cal_like)
      begin
        frame_status <= stat_r;
        frame_data   <= work_r;
        frame_crc_ok <= (val == snt_crc(work_r, n)); // RULE_16
      end
    end
  end

  // error: bad nibble, calibration mid-frame, or no calibration after pause
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      frame_err <= 1'b0;
    else
      frame_err <= fall && seen_r &&
                   (((st_r == SNT_RX_STAT || st_r == SNT_RX_DATA ||
                      st_r == SNT_RX_CRC) &&
                     ((cal_like && st_r != SNT_RX_STAT) || !nib_ok)) ||
                    ((st_r == SNT_RX_PAUSE) && !cal_like)); // RULE_20
  end

  assign cal_cycles = cal_r;
endmodule

`default_nettype wire

// ### hdl/snt_tx.sv
// What this block and the receiver do
// RULE_01: transmitter sends frames unprompted, no receiver trigger
// RULE_02: frames repeat back to back forever
// RULE_03: tick deviates at most twenty percent
// RULE_04: nominal tick lies between 3 and 90 us
// RULE_05: fixed pulse order lets receiver decode by position
// RULE_06: each frame opens with 56-tick calibration pulse
// RULE_07: one status nibble of 12 to 27 ticks
// RULE_08: one to six data nibbles follow status
// RULE_09: data nibble count fixed per application
// RULE_10: one checksum nibble follows the data
// RULE_11: optional single pause pulse after checksum
// RULE_12: nibble value x lasts 12 plus x ticks
// RULE_13: calibration pulse low over 4 ticks, rest high
// RULE_14: receiver scales decoding by measured calibration period
// RULE_15: longest six-nibble frame stays under 1 ms
// RULE_16: receiver runs diagnostics including 4-bit checksum
// RULE_17: receiver accepts up to eight data nibbles
// RULE_18: periods run falling edge to falling edge
// RULE_19: nibbles at least 12 ticks, low over 4
// RULE_20: receiver flags out-of-range nibbles or implausible calibration
`timescale 1ns/1ps
`default_nettype none
`include "snt_map.svh"

module snt_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                     (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      wr_ptr_r <= '0;
    else if (push)
      wr_ptr_r <= wr_ptr_r + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rd_ptr_r <= '0;
    else if (pop)
      rd_ptr_r <= rd_ptr_r + 1'b1;
  end
endmodule

module snt_tx
  import snt_pkg::*;
#(
  // cycles per tick; nominal tick must lie between 3 us and 90 us
  parameter int unsigned TICK_CYC = `SNT_TICK_CYC
) (
  // link
  snt_link_if.tx               link,
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  // frame words: status in 27:24, data nibble i in bits 4i+3:4i
  input  wire logic [27:0]     in_data,
  input  wire logic            in_valid,
  output logic                 in_ready,
  // fixed per application
  input  wire logic [2:0]      nib_cnt,
  input  wire logic            pause_en,
  // status
  output logic                 frame_start
);
  logic [27:0]   fifo_data;
  logic          fifo_valid;
  logic          fifo_pop;
  logic          run_r;
  logic [15:0]   pre_r;
  logic          tick;
  logic [5:0]    tk_r;
  logic [5:0]    len_r;
  logic [5:0]    len_nxt;
  logic          pulse_end;
  snt_tx_state_e st_r;
  snt_tx_state_e st_nxt;
  logic [2:0]    idx_r;
  logic [2:0]    idx_nxt;
  logic [27:0]   word_r;
  logic [2:0]    n_r;
  logic          pause_r;
  logic          load;
  snt_nibs_t     nibs;

  snt_fifo #(
    .WIDTH (`SNT_TX_W),
    .DEPTH (`SNT_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_data   (in_data),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign nibs = {8'h00, word_r[23:0]};

  // counters restart one edge after release, when the first fall is driven,
  // so the first low phase and calibration period are full length
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      run_r <= 1'b0;
    else
      run_r <= 1'b1;
  end

  // free-running tick; no input from the receiver ever gates it
  always_ff @(posedge ref_clk)
  begin
    if (!run_r || tick)
      pre_r <= '0;
    else
      pre_r <= pre_r + 1'b1; // RULE_01
  end

  assign tick      = (pre_r == 16'(TICK_CYC - 1)); // RULE_03
  assign pulse_end = tick && (tk_r == len_r - 1'b1);

  always_ff @(posedge ref_clk)
  begin
    if (!run_r || pulse_end)
      tk_r <= '0;
    else if (tick)
      tk_r <= tk_r + 1'b1;
  end

  // every pulse opens with a falling edge and stays low for 5 ticks
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      link.tx_out <= 1'b1;
      link.tx_oe  <= 1'b0;
    end
    else
    begin
      link.tx_out <= 1'b0;
      link.tx_oe  <= pulse_end || (tk_r < 6'(`SNT_LOW_TICKS - 1)) ||
                     ((tk_r == 6'(`SNT_LOW_TICKS - 1)) && !tick); // RULE_13 RULE_19 RULE_18
    end
  end

  always_comb
  begin
    st_nxt  = st_r;
    len_nxt = len_r;
    idx_nxt = idx_r;
    load    = 1'b0;
    case (st_r)
      SNT_TX_CAL:
      begin
        st_nxt  = SNT_TX_STAT; // RULE_05
        len_nxt = 6'(`SNT_NIB_TICKS) + {2'b00, word_r[27:24]}; // RULE_07
      end
      SNT_TX_STAT:
      begin
        st_nxt  = SNT_TX_DATA;
        idx_nxt = 3'h0;
        len_nxt = 6'(`SNT_NIB_TICKS) + {2'b00, snt_nib(nibs, 3'h0)}; // RULE_12
      end
      SNT_TX_DATA:
      begin
        if (idx_r == n_r - 1'b1)
        begin
          st_nxt  = SNT_TX_CRC; // RULE_10
          len_nxt = 6'(`SNT_NIB_TICKS) +
                    {2'b00, snt_crc(nibs, {1'b0, n_r})};
        end
        else
        begin
          idx_nxt = idx_r + 1'b1; // RULE_08
          len_nxt = 6'(`SNT_NIB_TICKS) +
                    {2'b00, snt_nib(nibs, idx_r + 1'b1)};
        end
      end
      SNT_TX_CRC:
      begin
        if (pause_r)
        begin
          st_nxt  = SNT_TX_PAUSE; // RULE_11
          len_nxt = 6'(`SNT_PAUSE_TICKS);
        end
        else
        begin
          st_nxt  = SNT_TX_CAL; // RULE_02
          len_nxt = 6'(`SNT_CAL_TICKS);
          load    = 1'b1;
        end
      end
      SNT_TX_PAUSE:
      begin
        st_nxt  = SNT_TX_CAL;
        len_nxt = 6'(`SNT_CAL_TICKS); // RULE_06
        load    = 1'b1;
      end
      default:
      begin
        st_nxt  = SNT_TX_CAL;
        len_nxt = 6'(`SNT_CAL_TICKS);
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r  <= SNT_TX_CAL;
      len_r <= 6'(`SNT_CAL_TICKS); // RULE_06
      idx_r <= 3'h0;
    end
    else if (pulse_end)
    begin
      st_r  <= st_nxt;
      len_r <= len_nxt;
      idx_r <= idx_nxt;
    end
  end

  // an empty queue repeats the last word so frames never stop
  assign fifo_pop = pulse_end && load;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      word_r <= '0;
    else if (fifo_pop && fifo_valid)
      word_r <= fifo_data; // RULE_02
  end

  // count and pause change only at frame boundaries
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      n_r     <= 3'(`SNT_TX_NIBS);
      pause_r <= 1'b0;
    end
    else if (fifo_pop)
    begin
      n_r     <= (nib_cnt == 3'h0 || nib_cnt > 3'(`SNT_TX_NIBS)) ?
                 3'(`SNT_TX_NIBS) : nib_cnt; // RULE_09
      pause_r <= pause_en;
    end
  end

  // with 6 nibbles at 3.6 us worst tick the frame is 272 ticks, under 1 ms
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      frame_start <= 1'b0;
    else
      frame_start <= fifo_pop; // RULE_15
  end
endmodule

`default_nettype wire
